// ---- core/cspr_consts.svh ----
/*
  Offsets, field positions, reset values and timing figures of the
  converter setpoint register bank.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef CSPR_CONSTS_SVH
`define CSPR_CONSTS_SVH

// =====================================================================
// Register subaddresses
`define CSPR_ADDR_B3      8'h18
`define CSPR_ADDR_B4      8'h19
`define CSPR_ADDR_SLEW    8'h1a

// =====================================================================
// Reset values, normal and alternate default selection
`define CSPR_B3_RST       8'h8c
`define CSPR_B4_RST       8'hb2
`define CSPR_B3_ALT       8'h84
`define CSPR_B4_ALT       8'ha8
`define CSPR_SLEW_RST     8'h06

// =====================================================================
// Field positions
`define CSPR_PSK_BIT      7
`define CSPR_RSV_BIT      6
`define CSPR_GO_BIT       7
`define CSPR_BYP_BIT      6
`define CSPR_SLEW_MSB     2

// =====================================================================
// Timing: blanking time in ms, clock in kHz, derived cycle count
`define CSPR_BLANK_MS     5
`define CSPR_CLK_KHZ      10000
`define CSPR_BLANK_CYC    (`CSPR_BLANK_MS * `CSPR_CLK_KHZ)
`define CSPR_STRAP_WAIT   2'h2

// =====================================================================
// Voltage code tables in mV: low base, low step, knee code,
// value at knee, high step
`define CSPR_B2_BASE      12'd850
`define CSPR_B2_STEP      12'd10
`define CSPR_B2_KNEE      6'h32
`define CSPR_B2_KMV       12'd1350
`define CSPR_B2_HSTEP     12'd25
`define CSPR_B3_BASE      12'd900
`define CSPR_B3_STEP      12'd25
`define CSPR_B3_KNEE      6'h1a
`define CSPR_B3_KMV       12'd1550
`define CSPR_B3_HSTEP     12'd50
`define CSPR_B4_BASE      12'd1175
`define CSPR_B4_STEP      12'd25
`define CSPR_B4_KNEE      6'h0f
`define CSPR_B4_KMV       12'd1550
`define CSPR_B4_HSTEP     12'd50
`define CSPR_B4_MAXCODE   6'h34

`endif

// ---- core/cspr_pkg.sv ----
/*
  Types of the converter setpoint register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package cspr_pkg;

  // Converter kind selecting a voltage table
  typedef enum logic [2:0] {
    CSPR_K_B2 = 3'b001,
    CSPR_K_B3 = 3'b010,
    CSPR_K_B4 = 3'b100
  } cspr_kind_t;

  // Monitor blanking state
  typedef enum logic [1:0] {
    CSPR_ST_RUN   = 2'b01,
    CSPR_ST_BLANK = 2'b10
  } cspr_blank_t;

endpackage

// ---- core/cspr_volt_decode.sv ----
/*
  Registered decoder from a 6-bit voltage code to millivolts.
  Assumes the code comes from logic on the same clock.
*/
`timescale 1ns/100ps
`include "cspr_consts.svh"

module cspr_volt_decode (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire cspr_pkg::cspr_kind_t kind,
  input  wire logic [5:0]           code,
  output logic      [11:0]          mv_q,
  output logic                      reserved_q
);
  import cspr_pkg::*;

  logic [11:0] mv_d;
  logic        reserved_d;
  logic [11:0] c12;
  logic [11:0] base;
  logic [11:0] step;
  logic [11:0] kmv;
  logic [11:0] hstep;
  logic [5:0]  knee;

  // =====================================================================
  // Two linear segments per table, joined at the knee code
  always_comb begin
    c12   = {6'h00, code};
    base  = `CSPR_B2_BASE;
    step  = `CSPR_B2_STEP;
    knee  = `CSPR_B2_KNEE;
    kmv   = `CSPR_B2_KMV;
    hstep = `CSPR_B2_HSTEP;
    reserved_d = 1'b0;
    case (kind)
      CSPR_K_B3: begin
        base  = `CSPR_B3_BASE;
        step  = `CSPR_B3_STEP;
        knee  = `CSPR_B3_KNEE;
        kmv   = `CSPR_B3_KMV;
        hstep = `CSPR_B3_HSTEP;
      end
      CSPR_K_B4: begin
        base  = `CSPR_B4_BASE;
        step  = `CSPR_B4_STEP;
        knee  = `CSPR_B4_KNEE;
        kmv   = `CSPR_B4_KMV;
        hstep = `CSPR_B4_HSTEP;
        reserved_d = (code > `CSPR_B4_MAXCODE); // R11 R08
      end
      default: begin
        base  = `CSPR_B2_BASE; // R10
      end
    endcase
    // Worst product 50*63 stays inside 12 bits
    if (code <= knee) begin
      mv_d = base + step * c12; // R10 R11
    end else begin
      mv_d = kmv + hstep * (c12 - {6'h00, knee}); // R10 R11
    end
  end

  // Register the result
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mv_q       <= 12'h000;
      reserved_q <= 1'b0;
    end else begin
      mv_q       <= mv_d;
      reserved_q <= reserved_d;
    end
  end

endmodule

// ---- core/cspr_regs.sv ----
/*
  Setpoint register bank of the third buck and fourth buck-boost
  converters, the trigger bits of the slew control register, monitor
  blanking after setpoint writes, and code-to-voltage decoding.
  Assumes a serial control port in front that issues one-cycle read
  and write strobes on sys_clk and judges the password itself.
*/
// Overview of operation
// R01: The third buck setpoint sits at 0x18 and resets to 0x8c.
// R02: The buck-boost setpoint sits at 0x19 and resets to 0xb2.
// R03: A write to the third buck setpoint blanks the monitor for 5 ms.
// R04: A write to the buck-boost setpoint blanks the monitor for 5 ms.
// R05: Both setpoints accept only writes that pass password protection.
// R06: Bit 7 is the pulse-skip enable, reset to one.
// R07: Bits 5-0 of the third buck hold its voltage code, reset 0x0c.
// R08: The host avoids reserved buck-boost codes and live code changes.
// R09: The power-up defaults follow the default-select input.
// R10: The second buck code maps to 0.850-1.675 V in two segments.
// R11: The buck-boost code maps to 1.175-3.400 V, codes above 34h reserved.
// R12: The host sets the trigger or bypass bit to apply a buck2 code.
// R13: The trigger bit clears itself when the transition is done.
// R14: Bit 6 of each setpoint reads zero and ignores writes.
// R15: A refused write changes nothing and starts no blanking.
`timescale 1ns/100ps
`include "cspr_consts.svh"

module cspr_regs #(
  parameter int BLANK_CYCLES = `CSPR_BLANK_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata_q,
  input  wire logic        write_unlocked,
  output logic             write_refused_q,
  input  wire logic        default_select_input,
  input  wire logic        ov_raw,
  input  wire logic        uv_raw,
  output logic             ov_flag_q,
  output logic             uv_flag_q,
  output logic             monitor_blank,
  input  wire logic        transition_done,
  output logic             go_pending,
  output logic             trigger_bypass,
  output logic      [2:0]  slew_rate,
  input  wire logic [5:0]  buck2_setpoint,
  output logic      [7:0]  buck3_setpoint,
  output logic      [7:0]  buckboost4_setpoint,
  output logic      [11:0] buck2_mv,
  output logic      [11:0] buck3_mv,
  output logic      [11:0] buckboost4_mv,
  output logic             buckboost4_reserved
);
  import cspr_pkg::*;

  // =====================================================================
  // Default-select synchroniser and strap capture after release
  logic       sel_s1_q;
  logic       sel_s2_q;
  logic [1:0] wait_q;
  logic [1:0] wait_d;
  logic       loaded_q;
  logic       loaded_d;
  logic       strap_load;

  // Wait for the synchroniser to fill before trusting the strap
  always_comb begin
    strap_load = !loaded_q && (wait_q == `CSPR_STRAP_WAIT);
    wait_d     = (wait_q == `CSPR_STRAP_WAIT) ? wait_q : wait_q + 2'h1;
    loaded_d   = loaded_q | strap_load;
  end

  // Two stages for a pin, then the strap sequencer
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
      wait_q   <= 2'h0;
      loaded_q <= 1'b0;
    end else begin
      sel_s1_q <= default_select_input;
      sel_s2_q <= sel_s1_q;
      wait_q   <= wait_d;
      loaded_q <= loaded_d;
    end
  end

  // =====================================================================
  // Register file
  logic [7:0] b3_q;
  logic [7:0] b3_d;
  logic [7:0] b4_q;
  logic [7:0] b4_d;
  logic       go_q;
  logic       go_d;
  logic       byp_q;
  logic       byp_d;
  logic [2:0] slew_q;
  logic [2:0] slew_d;
  logic [7:0] rdata_d;
  logic       refused_d;
  logic       wr_b3;
  logic       wr_b4;
  logic       wr_slew;
  logic       hit_sp;
  logic [7:0] sp_wval;

  // Decode, protection and next values
  always_comb begin
    hit_sp  = (reg_addr == `CSPR_ADDR_B3) || (reg_addr == `CSPR_ADDR_B4);
    wr_b3   = reg_wr && write_unlocked && (reg_addr == `CSPR_ADDR_B3); // R05
    wr_b4   = reg_wr && write_unlocked && (reg_addr == `CSPR_ADDR_B4); // R05
    wr_slew = reg_wr && (reg_addr == `CSPR_ADDR_SLEW);
    refused_d = reg_wr && !write_unlocked && hit_sp; // R15
    // Reserved bit never stored, so it always reads back zero
    sp_wval = reg_wdata;
    sp_wval[`CSPR_RSV_BIT] = 1'b0; // R14
    b3_d   = b3_q;
    b4_d   = b4_q;
    byp_d  = byp_q;
    slew_d = slew_q;
    if (strap_load) begin
      b3_d = sel_s2_q ? `CSPR_B3_ALT : `CSPR_B3_RST; // R09
      b4_d = sel_s2_q ? `CSPR_B4_ALT : `CSPR_B4_RST; // R09
    end else if (wr_b3) begin
      b3_d = sp_wval; // R06 R07
    end else if (wr_b4) begin
      b4_d = sp_wval; // R06
    end
    // Transition end clears the trigger, a fresh write wins
    go_d = go_q && !transition_done; // R13
    if (wr_slew) begin
      go_d   = reg_wdata[`CSPR_GO_BIT] | go_d;
      byp_d  = reg_wdata[`CSPR_BYP_BIT];
      slew_d = reg_wdata[`CSPR_SLEW_MSB:0];
    end
    rdata_d = 8'h00;
    if (reg_addr == `CSPR_ADDR_B3) begin
      rdata_d = b3_q;
    end else if (reg_addr == `CSPR_ADDR_B4) begin
      rdata_d = b4_q;
    end else if (reg_addr == `CSPR_ADDR_SLEW) begin
      rdata_d = {go_q, byp_q, 3'h0, slew_q};
    end
    if (!reg_rd) begin
      rdata_d = reg_rdata_q;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      b3_q            <= `CSPR_B3_RST; // R01 R06 R07
      b4_q            <= `CSPR_B4_RST; // R02 R06
      go_q            <= 1'b0;
      byp_q           <= 1'b0;
      slew_q          <= 3'(`CSPR_SLEW_RST);
      reg_rdata_q     <= 8'h00;
      write_refused_q <= 1'b0;
    end else begin
      b3_q            <= b3_d;
      b4_q            <= b4_d;
      go_q            <= go_d;
      byp_q           <= byp_d;
      slew_q          <= slew_d;
      reg_rdata_q     <= rdata_d;
      write_refused_q <= refused_d;
    end
  end

  assign buck3_setpoint      = b3_q;
  assign buckboost4_setpoint = b4_q;
  assign go_pending          = go_q;
  assign trigger_bypass      = byp_q;
  assign slew_rate           = slew_q;

  // =====================================================================
  // Monitor blanking; each accepted setpoint write restarts the window
  cspr_blank_t st_q;
  cspr_blank_t st_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        blank_kick;
  logic        ov_d;
  logic        uv_d;

  // Next state of the blanking window and gated monitor results
  always_comb begin
    blank_kick = wr_b3 || wr_b4; // R03 R04 R15
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      CSPR_ST_RUN: begin
        if (blank_kick) begin
          st_d  = CSPR_ST_BLANK;
          cnt_d = 16'h0000;
        end
      end
      CSPR_ST_BLANK: begin
        if (blank_kick) begin
          cnt_d = 16'h0000;
        end else if (cnt_q == 16'(BLANK_CYCLES - 1)) begin
          st_d = CSPR_ST_RUN; // R03 R04
        end else begin
          cnt_d = cnt_q + 16'h0001;
        end
      end
      default: begin
        st_d = CSPR_ST_RUN;
      end
    endcase
    ov_d = ov_raw && (st_q != CSPR_ST_BLANK); // R03 R04
    uv_d = uv_raw && (st_q != CSPR_ST_BLANK); // R03 R04
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q      <= CSPR_ST_RUN;
      cnt_q     <= 16'h0000;
      ov_flag_q <= 1'b0;
      uv_flag_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      cnt_q     <= cnt_d;
      ov_flag_q <= ov_d;
      uv_flag_q <= uv_d;
    end
  end

  assign monitor_blank = (st_q == CSPR_ST_BLANK);

  // =====================================================================
  // Voltage decoders, one per converter
  logic [5:0]  dec_code [3];
  logic [11:0] dec_mv   [3];
  logic        dec_rsv  [3];

  assign dec_code[0] = buck2_setpoint;
  assign dec_code[1] = b3_q[5:0];
  assign dec_code[2] = b4_q[5:0];

  for (genvar gi = 0; gi < 3; gi++) begin : g_dec
    localparam cspr_kind_t KIND = (gi == 0) ? CSPR_K_B2 :
                                  (gi == 1) ? CSPR_K_B3 : CSPR_K_B4;
    cspr_volt_decode u_dec (
      .sys_clk    (sys_clk),
      .reset      (reset),
      .kind       (KIND),
      .code       (dec_code[gi]),
      .mv_q       (dec_mv[gi]),
      .reserved_q (dec_rsv[gi])
    );
  end

  assign buck2_mv            = dec_mv[0];
  assign buck3_mv            = dec_mv[1];
  assign buckboost4_mv       = dec_mv[2];
  assign buckboost4_reserved = dec_rsv[2]; // R08

  // =====================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_wr_b3;
    reg_wr && write_unlocked && reg_addr == `CSPR_ADDR_B3 && !strap_load;
  endsequence
  sequence s_wr_b4;
    reg_wr && write_unlocked && reg_addr == `CSPR_ADDR_B4 && !strap_load;
  endsequence
  sequence s_refused;
    reg_wr && !write_unlocked && hit_sp && !strap_load;
  endsequence

  rst_value_a: assert property ($past(reset) |-> // R01
    b3_q == `CSPR_B3_RST && b4_q == `CSPR_B4_RST)
    else $error("setpoints not at reset values");
  strap_load_a: assert property (strap_load |=> // R09
    b4_q == ($past(sel_s2_q) ? `CSPR_B4_ALT : `CSPR_B4_RST))
    else $error("default select not applied");
  store_b3_a: assert property (s_wr_b3 |=> // R07
    b3_q == {$past(reg_wdata[7]), 1'b0, $past(reg_wdata[5:0])})
    else $error("setpoint write not stored");
  rsv_zero_a: assert property ($past(reg_rd) |-> // R14
    !(reg_rdata_q[`CSPR_RSV_BIT] && $past(hit_sp)))
    else $error("reserved bit read nonzero");
  refused_hold_a: assert property (s_refused |=> // R15
    $stable(b3_q) && $stable(b4_q) && write_refused_q)
    else $error("refused write altered state");
  refused_quiet_a: assert property (s_refused ##0 !monitor_blank |=> // R15
    !monitor_blank)
    else $error("refused write started blanking");
  blank_b3_a: assert property (s_wr_b3 |=> // R03
    monitor_blank ##1 !ov_flag_q)
    else $error("blanking not started after write");
  blank_b4_a: assert property (s_wr_b4 |=> // R04
    monitor_blank && cnt_q == 0)
    else $error("blanking not restarted after write");
  blank_end_a: assert property (monitor_blank && // R03
    cnt_q == 16'(BLANK_CYCLES - 1) && !blank_kick |=> !monitor_blank)
    else $error("blanking window wrong length");
  go_clear_a: assert property (go_q && transition_done && !wr_slew |=> // R13
    !go_q)
    else $error("trigger not cleared at transition end");

endmodule

// ---- dv/cspr_host.sv ----
/*
  Host model: drives the register port the way the serial control
  port in front of the bank does, one strobe per transfer.
  Assumes strobes are sampled on the rising edge of sys_clk.
*/
`timescale 1ns/100ps

module cspr_host (
  input  wire logic       sys_clk,
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_wdata,
  output logic            write_unlocked,
  input  wire logic [7:0] reg_rdata_q
);
  // =====================================================
  // Idle levels at time zero
  initial begin
    reg_addr       = 8'h00;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    reg_wdata      = 8'h00;
    write_unlocked = 1'b0;
  end

  // =====================================================
  // Write: lines are inverted on release so nothing can
  // lean on a stale address or data byte
  // Callers keep buck-boost codes at or below 34h
  task automatic wr(input logic [7:0] addr, input logic [7:0] data,
                    input logic unl);
    @(posedge sys_clk);
    reg_addr       <= addr;
    reg_wdata      <= data;
    write_unlocked <= unl;
    reg_wr         <= 1'b1;
    @(posedge sys_clk);
    reg_wr         <= 1'b0;
    reg_addr       <= ~addr;
    reg_wdata      <= ~data;
    write_unlocked <= 1'b0;
    #1;
  endtask

  // =====================================================
  // Read: data is registered, taken once the edge settles
  task automatic rd(input logic [7:0] addr, output logic [7:0] data);
    @(posedge sys_clk);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~addr;
    #1;
    data = reg_rdata_q;
  endtask
endmodule

// ---- dv/tb_top.sv ----
/*
  Self-checking bench of the converter setpoint register bank.
  Assumes cspr_consts.svh on the include path and the host model.
*/
`timescale 1ns/100ps
`include "cspr_consts.svh"

module tb_top;
  localparam int BLANK = 20;
  logic        sys_clk              = 1'b0;
  logic        reset                = 1'b1;
  logic        default_select_input = 1'b0;
  logic        ov_raw               = 1'b0;
  logic        uv_raw               = 1'b0;
  logic        transition_done      = 1'b0;
  logic [5:0]  buck2_setpoint       = 6'h00;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q, b3, b4, rdat;
  logic        reg_wr, reg_rd, write_unlocked, write_refused_q;
  logic        ov_flag_q, uv_flag_q, monitor_blank, go_pending;
  logic        trigger_bypass, b4_rsv;
  logic [2:0]  slew_rate;
  logic [11:0] b2_mv, b3_mv, b4_mv;
  logic [5:0]  c2 [4] = '{6'h00, 6'h32, 6'h33, 6'h3f};
  logic [5:0]  c3 [4] = '{6'h00, 6'h1a, 6'h1b, 6'h3f};
  logic [5:0]  c4 [4] = '{6'h00, 6'h0f, 6'h10, 6'h34};
  int          n_mismatch  = 0;
  int          checks_done = 0;
  int          cycles      = 0;

  // =====================================================
  // Clock, design and host
  always #50 sys_clk = ~sys_clk;

  cspr_regs #(.BLANK_CYCLES(BLANK)) uut (
    .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .write_unlocked(write_unlocked),
    .write_refused_q(write_refused_q),
    .default_select_input(default_select_input),
    .ov_raw(ov_raw), .uv_raw(uv_raw), .ov_flag_q(ov_flag_q),
    .uv_flag_q(uv_flag_q), .monitor_blank(monitor_blank),
    .transition_done(transition_done), .go_pending(go_pending),
    .trigger_bypass(trigger_bypass), .slew_rate(slew_rate),
    .buck2_setpoint(buck2_setpoint), .buck3_setpoint(b3),
    .buckboost4_setpoint(b4), .buck2_mv(b2_mv), .buck3_mv(b3_mv),
    .buckboost4_mv(b4_mv), .buckboost4_reserved(b4_rsv));

  cspr_host host (
    .sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .write_unlocked(write_unlocked), .reg_rdata_q(reg_rdata_q));

  // =====================================================
  // Helpers
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] exp,
                     input string what);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
    host.rd(addr, rdat);
    chk({4'h0, rdat}, {4'h0, exp}, "read");
  endtask

  // Piecewise code table in mV, knee is the last low-segment code
  function automatic logic [11:0] mv(input int c, kn, b, s, hb, hs);
    return (c <= kn) ? 12'(b + s * c) : 12'(hb + hs * (c - kn - 1));
  endfunction

  // Select must be steady well before release, so set it first
  task automatic do_reset(input logic sel);
    default_select_input <= sel;
    reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  // Monitor results held high; blanking must mask them exactly
  task automatic blank_run(input string what);
    int n;
    n = 0;
    while (monitor_blank === 1'b1 && n < 1000) begin
      if (n == 1)
        chk({10'h0, ov_flag_q, uv_flag_q}, 12'h0, what);
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(12'(n), 12'(BLANK), what);
    @(posedge sys_clk);
    #1;
    chk({10'h0, ov_flag_q, uv_flag_q}, 12'h3, what);
  endtask

  // =====================================================
  // Hang guard, far above the 130 or so cycles needed
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_mismatch++;
      test_done();
    end
  end

  // =====================================================
  // Main sequence
  initial begin
    do_reset(1'b0);
    rchk(8'h18, 8'h8c);
    rchk(8'h19, 8'hb2);
    rchk(8'h1a, 8'h06);
    rchk(8'h20, 8'h00);
    chk(b3_mv, 12'd1200, "b3 reset mv");
    ov_raw <= 1'b1;
    uv_raw <= 1'b1;
    host.wr(8'h18, 8'h00, 1'b0);
    chk({10'h0, write_refused_q, monitor_blank}, 12'h2, "lock");
    rchk(8'h18, 8'h8c);
    chk({4'h0, b3}, 12'h08c, "b3 held");
    host.wr(8'h18, 8'hff, 1'b1);
    blank_run("b3 blank");
    rchk(8'h18, 8'hbf);
    // Second write mid-window must restart the count
    host.wr(8'h19, 8'h74, 1'b1);
    repeat (5) @(posedge sys_clk);
    host.wr(8'h19, 8'h74, 1'b1);
    blank_run("b4 blank");
    rchk(8'h19, 8'h34);
    chk({4'h0, b4}, 12'h034, "b4 out");
    for (int i = 0; i < 4; i++) begin
      host.wr(8'h18, {2'b10, c3[i]}, 1'b1);
      host.wr(8'h19, {2'b10, c4[i]}, 1'b1);
      buck2_setpoint <= c2[i];
      repeat (2) @(posedge sys_clk);
      #1;
      chk(b3_mv, mv(c3[i], 26, 900, 25, 1600, 50), "b3 mv");
      chk(b4_mv, mv(c4[i], 15, 1175, 25, 1600, 50), "b4 mv");
      chk(b2_mv, mv(c2[i], 50, 850, 10, 1375, 25), "b2 mv");
      chk({11'h0, b4_rsv}, 12'h0, "b4 rsv");
    end
    host.wr(8'h1a, 8'hfe, 1'b0);
    chk({go_pending, trigger_bypass, 7'h0, slew_rate}, 12'hc06, "go");
    rchk(8'h1a, 8'hc6);
    host.wr(8'h1a, 8'h06, 1'b0);
    chk({go_pending, trigger_bypass, 7'h0, slew_rate}, 12'h806, "hold");
    @(posedge sys_clk);
    transition_done <= 1'b1;
    @(posedge sys_clk);
    transition_done <= 1'b0;
    #1;
    chk({11'h0, go_pending}, 12'h0, "go clear");
    do_reset(1'b1);
    rchk(8'h18, `CSPR_B3_ALT);
    rchk(8'h19, `CSPR_B4_ALT);
    test_done();
  end
endmodule
